/* hw/dmse_pkg.sv */
package dmse_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // array geometry
    localparam int             ADDR_W    = 7;
    localparam int             DATA_W    = 8;
    localparam int             MEM_DEPTH = 128;
    localparam int             PAGE_W    = 3;
    localparam logic [6:0]     ADDR_RST  = 7'h00;
    localparam logic [6:0]     ADDR_STEP = 7'h01;

    ////////////////////////////////////////////////////////////////////////////////
    // slave address byte: device code in b7..b4, chip enables in b3..b1
    localparam int             CODE_MSB     = 7;
    localparam int             CODE_LSB     = 4;
    localparam int             CE_MSB       = 3;
    localparam int             CE_LSB       = 1;
    localparam int             RW_BIT       = 0;
    localparam logic [2:0]     CE_FIXED     = 3'h0;
    // arbitrary neutral value, override per product
    localparam logic [3:0]     DEV_CODE_DEF = 4'h5;

    ////////////////////////////////////////////////////////////////////////////////
    // transmit-only stream timing, counted in transmit-only clock pulses; BYTE_BITS counts the scl bits of a serial byte
    localparam logic [3:0]     INIT_PULSES = 4'h9;
    localparam logic [3:0]     DC_SLOT     = 4'h8;
    localparam logic [3:0]     BYTE_BITS   = 4'h8;
    localparam logic [7:0]     REVERT_PULSES = 8'h80;

    ////////////////////////////////////////////////////////////////////////////////
    // recovery timer, in core clock cycles
    localparam int             CLK_PERIOD_NS   = 4;
    localparam int             RECOVERY_MS     = 2000;
    localparam int             RECOVERY_CYCLES = RECOVERY_MS * (1000000 / CLK_PERIOD_NS);
    localparam int             TIMER_W         = 29;

    ////////////////////////////////////////////////////////////////////////////////
    // sync register reset: {link toggle, scl, sda, write control}, lines idle high
    localparam logic [3:0]     SYNC_RST = 4'h6;

    typedef enum logic [1:0] {
        MODE_TX    = 2'b00,
        MODE_TRANS = 2'b01,
        MODE_I2C   = 2'b10
    } dmse_mode_t;

    typedef enum logic [3:0] {
        ST_IDLE      = 4'b0000,
        ST_DEV       = 4'b0001,
        ST_DEV_ACK   = 4'b0010,
        ST_WORD      = 4'b0011,
        ST_WORD_ACK  = 4'b0100,
        ST_WRITE     = 4'b0101,
        ST_WRITE_ACK = 4'b0110,
        ST_READ      = 4'b0111,
        ST_READ_ACK  = 4'b1000
    } dmse_i2c_t;

    typedef struct packed {
        logic       en;
        logic [6:0] addr;
        logic [7:0] data;
    } dmse_wr_t;

endpackage : dmse_pkg

/* hw/dmse_mem.sv */
`timescale 1ns/1ps
module dmse_mem #(
    parameter int AddrW = dmse_pkg::ADDR_W,
    parameter int DataW = dmse_pkg::DATA_W
) (
    // clock and reset
    input  wire logic               core_clk,
    input  wire logic               nrst,
    // write port
    input  wire dmse_pkg::dmse_wr_t wr,
    // read port
    input  wire logic [AddrW-1:0]   rdAddr,
    output logic      [DataW-1:0]   rdData
);
    import dmse_pkg::*;

    logic [DataW-1:0] memReg [2**AddrW];
    logic [DataW-1:0] rdDataNext;

    always_comb begin
        rdDataNext = memReg[rdAddr];
    end

    // cleared at reset so the stream never shows unknown bits; a real part keeps contents
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < 2**AddrW; i++) begin
                memReg[i] <= '0;
            end
            rdData <= '0;
        end else begin
            if (wr.en) begin
                memReg[wr.addr] <= wr.data;
            end
            rdData <= rdDataNext;
        end
    end

endmodule : dmse_mem

/* hw/dmse_iface.sv */
`timescale 1ns/1ps
module dmse_iface #(
    parameter logic [3:0]  DevCode        = dmse_pkg::DEV_CODE_DEF,
    parameter bit          ErrRecovery    = 1'b1,
    parameter bit          FixedAddr      = 1'b0,
    parameter int unsigned RecoveryCycles = dmse_pkg::RECOVERY_CYCLES
) (
    // core clock and reset
    input  wire logic             core_clk,
    input  wire logic             nrst,
    // transmit-only link clock
    input  wire logic             transmitOnlyClock,
    // serial pins, open drain data
    input  wire logic             sclIn,
    input  wire logic             sdaIn,
    output logic                  sdaOut,
    output logic                  sdaOe,
    // write enable pin
    input  wire logic             writeControlInput,
    // status
    output dmse_pkg::dmse_mode_t  modeOut
);
    import dmse_pkg::*;

    localparam logic [TIMER_W-1:0] TimerLast = TIMER_W'(RecoveryCycles - 1);

    function automatic logic devMatch(input logic [7:0] b);
        logic ceOk;
        ceOk = !FixedAddr || (b[CE_MSB:CE_LSB] == CE_FIXED);
        return (b[CODE_MSB:CODE_LSB] == DevCode) && ceOk;
    endfunction : devMatch
    ////////////////////////////////////////////////////////////////////////////////
    // link domain: one toggle per rising transmit-only clock edge
    logic vTglReg;
    logic vTglNext;

    always_comb begin
        vTglNext = ~vTglReg;
    end

    always_ff @(posedge transmitOnlyClock or negedge nrst) begin
        if (!nrst) begin
            vTglReg <= 1'b0;
        end else begin
            vTglReg <= vTglNext;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // synchronisers: {link toggle, scl, sda, write control}
    logic [3:0] syncA_reg,   syncA_next;
    logic [3:0] syncB_reg,   syncB_next;
    logic       vTgl3_reg,   vTgl3_next;
    logic       sclPrev_reg, sclPrev_next;
    logic       sdaPrev_reg, sdaPrev_next;

    always_comb begin
        syncA_next   = {vTglReg, sclIn, sdaIn, writeControlInput};
        syncB_next   = syncA_reg;
        vTgl3_next   = syncB_reg[3];
        sclPrev_next = syncB_reg[2];
        sdaPrev_next = syncB_reg[1];
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            syncA_reg   <= SYNC_RST;
            syncB_reg   <= SYNC_RST;
            vTgl3_reg   <= 1'b0;
            sclPrev_reg <= 1'b1;
            sdaPrev_reg <= 1'b1;
        end else begin
            syncA_reg   <= syncA_next;
            syncB_reg   <= syncB_next;
            vTgl3_reg   <= vTgl3_next;
            sclPrev_reg <= sclPrev_next;
            sdaPrev_reg <= sdaPrev_next;
        end
    end

    logic vEvt,    sclS,    sdaS,     wrCtlS;
    logic sclFall, sclRise, startDet, stopDet;
    assign vEvt     = syncB_reg[3] ^ vTgl3_reg;
    assign sclS     = syncB_reg[2];
    assign sdaS     = syncB_reg[1];
    assign wrCtlS   = syncB_reg[0];
    assign sclFall  = sclPrev_reg & ~sclS;
    assign sclRise  = ~sclPrev_reg & sclS;
    assign startDet = sclS & sclPrev_reg & sdaPrev_reg & ~sdaS;
    assign stopDet  = sclS & sclPrev_reg & ~sdaPrev_reg & sdaS;
    ////////////////////////////////////////////////////////////////////////////////
    // control state
    dmse_mode_t         mode_reg,     mode_next;
    dmse_i2c_t          st_reg,       st_next;
    logic [3:0]         bitCnt_reg,   bitCnt_next;
    logic [7:0]         shift_reg,    shift_next;
    logic [ADDR_W-1:0]  addr_reg,     addr_next;
    logic [3:0]         initCnt_reg,  initCnt_next;
    logic [3:0]         txPos_reg,    txPos_next;
    logic [7:0]         revCnt_reg,   revCnt_next;
    logic [TIMER_W-1:0] timer_reg,    timer_next;
    logic               sdaOe_reg,    sdaOe_next;
    logic               sdaOut_reg,   sdaOut_next;
    logic               rw_reg,       rw_next;
    logic               acked_reg,    acked_next;
    logic               addrInc;
    logic               devAckNow;
    logic [7:0]         memRdData;
    dmse_wr_t           memWr;
    dmse_mem #(.AddrW (ADDR_W), .DataW (DATA_W)) u_mem (
        .core_clk (core_clk),
        .nrst     (nrst),
        .wr       (memWr),
        .rdAddr   (addr_reg),
        .rdData   (memRdData)
    );

    always_comb begin
        mode_next    = mode_reg;
        st_next      = st_reg;
        bitCnt_next  = bitCnt_reg;
        shift_next   = shift_reg;
        addr_next    = addr_reg;
        initCnt_next = initCnt_reg;
        txPos_next   = txPos_reg;
        revCnt_next  = revCnt_reg;
        timer_next   = timer_reg;
        sdaOe_next   = sdaOe_reg;
        sdaOut_next  = 1'b0;
        rw_next      = rw_reg;
        acked_next   = acked_reg;
        addrInc      = 1'b0;
        devAckNow    = 1'b0;
        memWr        = '0;
        unique case (mode_reg)
            MODE_TX: begin
                if (sclFall) begin
                    mode_next   = ErrRecovery ? MODE_TRANS : MODE_I2C;
                    st_next     = ST_IDLE;
                    sdaOe_next  = 1'b0;
                    revCnt_next = '0;
                    timer_next  = '0;
                end else if (vEvt && sclS) begin
                    if (initCnt_reg < INIT_PULSES) begin
                        initCnt_next = initCnt_reg + 4'h1;
                        sdaOe_next   = 1'b0;
                    end else if (txPos_reg == DC_SLOT) begin
                        txPos_next = 4'h0;
                        sdaOe_next = 1'b0;
                        addrInc    = 1'b1;
                    end else begin
                        sdaOe_next = ~memRdData[~txPos_reg[2:0]];
                        txPos_next = txPos_reg + 4'h1;
                    end
                end
            end
            MODE_TRANS, MODE_I2C: begin
                if (startDet) begin
                    st_next     = ST_DEV;
                    bitCnt_next = 4'h0;
                    sdaOe_next  = 1'b0;
                end else if (stopDet) begin
                    st_next    = ST_IDLE;
                    sdaOe_next = 1'b0;
                end else begin
                    unique case (st_reg)
                        ST_IDLE: begin
                            sdaOe_next = 1'b0;
                        end
                        ST_DEV, ST_WORD, ST_WRITE: begin
                            if (sclRise && bitCnt_reg < BYTE_BITS) begin
                                shift_next  = {shift_reg[6:0], sdaS};
                                bitCnt_next = bitCnt_reg + 4'h1;
                            end else if (sclFall && bitCnt_reg == BYTE_BITS) begin
                                bitCnt_next = 4'h0;
                                sdaOe_next  = 1'b1;
                                if (st_reg == ST_DEV) begin
                                    if (devMatch(shift_reg)) begin
                                        st_next   = ST_DEV_ACK;
                                        rw_next   = shift_reg[RW_BIT];
                                        devAckNow = 1'b1;
                                    end else begin
                                        st_next    = ST_IDLE;
                                        sdaOe_next = 1'b0;
                                    end
                                end else if (st_reg == ST_WORD) begin
                                    st_next   = ST_WORD_ACK;
                                    addr_next = shift_reg[ADDR_W-1:0];
                                end else begin
                                    st_next    = ST_WRITE_ACK;
                                    memWr.en   = wrCtlS;
                                    memWr.addr = addr_reg;
                                    memWr.data = shift_reg;
                                    // page writes roll over inside the 8-byte page
                                    addr_next  = {addr_reg[ADDR_W-1:PAGE_W],
                                                  addr_reg[PAGE_W-1:0] + 3'h1};
                                end
                            end
                        end
                        ST_DEV_ACK, ST_WORD_ACK, ST_WRITE_ACK: begin
                            if (sclFall) begin
                                bitCnt_next = 4'h0;
                                sdaOe_next  = 1'b0;
                                if (st_reg == ST_DEV_ACK && rw_reg) begin
                                    st_next     = ST_READ;
                                    shift_next  = memRdData;
                                    sdaOe_next  = ~memRdData[7];
                                    bitCnt_next = 4'h1;
                                end else if (st_reg == ST_DEV_ACK) begin
                                    st_next = ST_WORD;
                                end else begin
                                    st_next = ST_WRITE;
                                end
                            end
                        end
                        ST_READ: begin
                            if (sclFall && bitCnt_reg == BYTE_BITS) begin
                                st_next    = ST_READ_ACK;
                                sdaOe_next = 1'b0;
                                acked_next = 1'b0;
                            end else if (sclFall) begin
                                shift_next  = {shift_reg[6:0], 1'b0};
                                sdaOe_next  = ~shift_reg[6];
                                bitCnt_next = bitCnt_reg + 4'h1;
                            end
                        end
                        ST_READ_ACK: begin
                            if (sclRise) begin
                                acked_next = ~sdaS;
                                addrInc    = ~sdaS;
                            end else if (sclFall && acked_reg) begin
                                st_next     = ST_READ;
                                shift_next  = memRdData;
                                sdaOe_next  = ~memRdData[7];
                                bitCnt_next = 4'h1;
                            end else if (sclFall) begin
                                st_next = ST_IDLE;
                            end
                        end
                        default: begin
                            st_next    = ST_IDLE;
                            sdaOe_next = 1'b0;
                        end
                    endcase
                end
                if (mode_reg == MODE_TRANS) begin
                    if (devAckNow) begin
                        mode_next = MODE_I2C;
                    end else if (sclFall) begin
                        revCnt_next = '0;
                        timer_next  = '0;
                    end else if ((vEvt && revCnt_reg == REVERT_PULSES - 8'h01)
                                 || timer_reg == TimerLast) begin
                        mode_next  = MODE_TX;
                        st_next    = ST_IDLE;
                        sdaOe_next = 1'b0;
                        txPos_next = 4'h0;
                    end else begin
                        revCnt_next = revCnt_reg + {7'h00, vEvt};
                        timer_next  = timer_reg + {{(TIMER_W-1){1'b0}}, 1'b1};
                    end
                end
            end
            default: begin
                mode_next  = MODE_TX;
                sdaOe_next = 1'b0;
            end
        endcase
        if (addrInc) begin
            addr_next = addr_reg + ADDR_STEP;
        end
    end
    // only power-on reset leaves bidirectional mode in the sticky variant
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            mode_reg    <= MODE_TX;
            st_reg      <= ST_IDLE;
            bitCnt_reg  <= 4'h0;
            shift_reg   <= 8'h00;
            addr_reg    <= ADDR_RST;
            initCnt_reg <= 4'h0;
            txPos_reg   <= 4'h0;
            revCnt_reg  <= 8'h00;
            timer_reg   <= '0;
            sdaOe_reg   <= 1'b0;
            sdaOut_reg  <= 1'b0;
            rw_reg      <= 1'b0;
            acked_reg   <= 1'b0;
        end else begin
            mode_reg    <= mode_next;
            st_reg      <= st_next;
            bitCnt_reg  <= bitCnt_next;
            shift_reg   <= shift_next;
            addr_reg    <= addr_next;
            initCnt_reg <= initCnt_next;
            txPos_reg   <= txPos_next;
            revCnt_reg  <= revCnt_next;
            timer_reg   <= timer_next;
            sdaOe_reg   <= sdaOe_next;
            sdaOut_reg  <= sdaOut_next;
            rw_reg      <= rw_next;
            acked_reg   <= acked_next;
        end
    end
    assign sdaOe   = sdaOe_reg;
    assign sdaOut  = sdaOut_reg;
    assign modeOut = mode_reg;
    ////////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    sequence tenthPulse_s;
        mode_reg == MODE_TX && !sclFall && vEvt && sclS && initCnt_reg == INIT_PULSES
            && txPos_reg == 4'h0 && addr_reg == ADDR_RST;
    endsequence
    sequence devByteDone_s;
        mode_reg != MODE_TX && st_reg == ST_DEV && !startDet && !stopDet && sclFall
            && bitCnt_reg == BYTE_BITS;
    endsequence
    init_hiz_a: assert property ((mode_reg == MODE_TX && initCnt_reg < INIT_PULSES)
        |=> !sdaOe_reg) else $error("data line driven during init pulses");
    tenth_msb_a: assert property (tenthPulse_s |=> sdaOe_reg == ~$past(memRdData[7]))
        else $error("tenth pulse did not drive msb of byte zero");
    tx_slot_a: assert property ((mode_reg == MODE_TX && !sclFall && vEvt && sclS
        && initCnt_reg == INIT_PULSES && txPos_reg == DC_SLOT)
        |=> txPos_reg == 4'h0 && !sdaOe_reg && addr_reg == $past(addr_reg) + ADDR_STEP)
        else $error("don't-care slot mishandled");
    scl_exit_a: assert property ((mode_reg == MODE_TX && sclFall)
        |=> mode_reg == (ErrRecovery ? MODE_TRANS : MODE_I2C))
        else $error("scl fall did not leave transmit-only mode");
    mode_sticky_a: assert property ((!ErrRecovery && mode_reg == MODE_I2C)
        |=> mode_reg == MODE_I2C) else $error("sticky variant left bidirectional mode");
    revert_limit_a: assert property ((mode_reg == MODE_TRANS && !sclFall && !devAckNow
        && vEvt && revCnt_reg == REVERT_PULSES - 8'h01) |=> mode_reg == MODE_TX)
        else $error("no revert after pulse limit");
    restart_clr_a: assert property ((mode_reg == MODE_TRANS && sclFall && !devAckNow)
        |=> revCnt_reg == 8'h00 && timer_reg == '0) else $error("revert interval not restarted");
    addr_wrap_a: assert property ((addrInc && addr_reg == 7'h7f) |=> addr_reg == ADDR_RST)
        else $error("address counter did not wrap");
    write_gate_a: assert property (memWr.en |-> wrCtlS && st_reg == ST_WRITE)
        else $error("write executed with write control low");
    dev_ack_a: assert property (devByteDone_s ##0 devMatch(shift_reg)
        |=> (sdaOe_reg && st_reg == ST_DEV_ACK)) else $error("select byte not acknowledged");

endmodule : dmse_iface

/* verification/dmse_host_model.sv */
`timescale 1ns/1ps
module dmse_host_model (
    // pacing clock
    input  wire logic core_clk,
    // link clock and serial lines
    output logic      linkClk,
    output logic      scl,
    output logic      hostPull,
    input  wire logic sda,
    // bytes read back
    output logic       rdValid,
    output logic [7:0] rdData
);
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        linkClk = 1'b0;
        scl = 1'b1;
        hostPull = 1'b0;
        rdValid = 1'b0;
        rdData = 8'h00;
    end
    task automatic waitCyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask : waitCyc
    // link clock stands still between calls
    task automatic linkPulse();
        linkClk = 1'b1;
        #15 linkClk = 1'b0;
        #15;
    endtask : linkPulse
    task automatic sclFall();
        scl = 1'b0;
        waitCyc(15);
        scl = 1'b1;
        waitCyc(15);
    endtask : sclFall
    // b=1 releases the line; data only moves while scl is low
    task automatic bitCycle(input logic b, output logic seen);
        hostPull = ~b;
        waitCyc(15);
        scl = 1'b1;
        waitCyc(8);
        seen = sda;
        waitCyc(7);
        scl = 1'b0;
        waitCyc(3);
    endtask : bitCycle
    task automatic start();
        hostPull = 1'b0;
        waitCyc(4);
        scl = 1'b1;
        waitCyc(15);
        hostPull = 1'b1;
        waitCyc(15);
        scl = 1'b0;
        waitCyc(3);
    endtask : start
    task automatic stop();
        hostPull = 1'b1;
        waitCyc(4);
        scl = 1'b1;
        waitCyc(15);
        hostPull = 1'b0;
        waitCyc(15);
    endtask : stop
    task automatic wrByte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bitCycle(b[i], s);
        bitCycle(1'b1, s);
        ack = ~s;
    endtask : wrByte
    task automatic rdByte(input logic mAck);
        logic [7:0] d;
        logic       s;
        for (int i = 7; i >= 0; i--) bitCycle(1'b1, d[i]);
        bitCycle(~mAck, s);
        rdData = d;
        rdValid = 1'b1;
        waitCyc(1);
        rdValid = 1'b0;
    endtask : rdByte
endmodule : dmse_host_model

/* verification/dmse_iface_tb_top.sv */
`timescale 1ns/1ps
module dmse_iface_tb_top;
    import dmse_pkg::*;
    // arbitrary device code for this bench
    localparam logic [3:0] Code = 4'h5;
    logic       core_clk = 1'b0;
    logic       nrst, wrCtlIn, sdaOut, sdaOe, linkClk, scl, hostPull, rdValid;
    logic [7:0] rdData;
    logic [7:0] d [3];
    logic [7:0] expQ [$];
    dmse_mode_t modeOut;
    wire        sdaWire;
    int         failCount = 0;
    int         checkCount = 0;
    int         seed = 24;
    // open drain line with pull-up
    assign sdaWire = ~(sdaOe | hostPull);
    always #2 core_clk = ~core_clk;
    dmse_iface #(.DevCode(Code), .ErrRecovery(1'b1), .FixedAddr(1'b0), .RecoveryCycles(2000))
    i_dmse_iface (.core_clk(core_clk), .nrst(nrst), .transmitOnlyClock(linkClk), .sclIn(scl),
        .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOe(sdaOe), .writeControlInput(wrCtlIn),
        .modeOut(modeOut));
    dmse_host_model i_dmse_host_model (.core_clk(core_clk), .linkClk(linkClk), .scl(scl),
        .hostPull(hostPull), .sda(sdaWire), .rdValid(rdValid), .rdData(rdData));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checkCount++;
        if (seen !== exp) begin
            failCount++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic giveVerdict();
        $display("checks %0d mismatches %0d", checkCount, failCount);
        if (failCount == 0 && checkCount > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : giveVerdict
    task automatic sendExp(input logic [7:0] b, input logic expAck);
        logic a;
        i_dmse_host_model.wrByte(b, a);
        check("ack", {7'h00, a}, {7'h00, expAck});
    endtask : sendExp
    task automatic modeIs(input dmse_mode_t m);
        check("mode", {6'h00, modeOut}, {6'h00, m});
    endtask : modeIs
    task automatic addrWrite(input logic [6:0] a);
        i_dmse_host_model.start();
        sendExp({Code, 3'h5, 1'b0}, 1'b1);
        sendExp({1'b0, a}, 1'b1);
    endtask : addrWrite
    task automatic pulses(input int n);
        repeat (n) i_dmse_host_model.linkPulse();
        repeat (6) @(negedge core_clk);
    endtask : pulses
    // whole bytes only; the last one is not acknowledged
    task automatic readAt(input logic [6:0] a, input int n);
        addrWrite(a);
        i_dmse_host_model.start();
        sendExp({Code, 3'h0, 1'b1}, 1'b1);
        for (int k = 1; k <= n; k++) i_dmse_host_model.rdByte(k < n);
        i_dmse_host_model.stop();
    endtask : readAt
    always @(posedge core_clk) begin
        if (rdValid === 1'b1) begin
            if (expQ.size() == 0) check("extra read", {7'h00, rdValid}, 8'h00);
            else check("read data", rdData, expQ.pop_front());
        end
    end
    initial begin
        // about four times the expected run length
        #200000;
        failCount++;
        giveVerdict();
    end
    initial begin
        nrst = 1'b0;
        wrCtlIn = 1'b1;
        repeat (10) @(negedge core_clk);
        nrst = 1'b1;
        repeat (4) @(negedge core_clk);
        for (int i = 1; i <= 18; i++) begin
            i_dmse_host_model.linkPulse();
            check("stream", {7'h00, sdaOe}, {7'h00, (i >= 10 && i <= 17)});
        end
        modeIs(MODE_TX);
        i_dmse_host_model.sclFall();
        modeIs(MODE_TRANS);
        pulses(100);
        i_dmse_host_model.sclFall();
        pulses(127);
        modeIs(MODE_TRANS);
        pulses(1);
        modeIs(MODE_TX);
        i_dmse_host_model.sclFall();
        i_dmse_host_model.start();
        sendExp({4'h3, 3'h0, 1'b0}, 1'b0);
        i_dmse_host_model.stop();
        modeIs(MODE_TRANS);
        // no scl activity: the recovery timer alone must revert
        repeat (2000) @(negedge core_clk);
        modeIs(MODE_TX);
        i_dmse_host_model.sclFall();
        foreach (d[i]) d[i] = 8'($random(seed));
        addrWrite(7'h7e);
        modeIs(MODE_I2C);
        foreach (d[i]) sendExp(d[i], 1'b1);
        i_dmse_host_model.stop();
        wrCtlIn = 1'b0;
        addrWrite(7'h10);
        sendExp(8'hff, 1'b1);
        i_dmse_host_model.stop();
        wrCtlIn = 1'b1;
        expQ = {d[0], d[1], 8'h00, 8'h00, d[2], 8'h00};
        readAt(7'h7e, 3);
        i_dmse_host_model.start();
        sendExp({Code, 3'h2, 1'b1}, 1'b1);
        i_dmse_host_model.rdByte(1'b0);
        i_dmse_host_model.stop();
        readAt(7'h78, 1);
        readAt(7'h10, 1);
        check("pending", 8'(expQ.size()), 8'h00);
        pulses(3);
        modeIs(MODE_I2C);
        check("sda out", {7'h00, sdaOut}, 8'h00);
        giveVerdict();
    end
endmodule : dmse_iface_tb_top
